// file: verilog/otp_trim_verify_defaults.sv
// Functional notes
// R1: margin load senses fuses against a lower reference, latches result.
// R2: margin result replaces the upper sixteen bits of the trim word.
// R3: master reads the trim word after margin load to get the result.
// R4: master rejects part unless margin readback shows word and pattern.
// R5: blank load senses fuses against a higher reference, latches result.
// R6: blank result lands in bits twenty down to thirteen of trim word.
// R7: master rejects part if blank readback lacks programmed word and pattern.
// R8: last frame bit gives the whole answer frame odd parity.
// R9: peak select sets buck 1 peak code at reset via fixed table.
// R10: off-time select sets buck 1 volt-time code at reset via table.
// R11: master programs by writing burn command with word, three times.
// R12: latched sense result holds across reads until the next load.
`timescale 1ns/1ns
`default_nettype none
module otp_trim_verify_defaults (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// decoded serial frames from the interface logic
	input wire logic frame_valid_i,
	input wire logic [31:0] frame_i,
	input wire logic [7:0] status_i,
	// answer frame towards the serial output
	output logic resp_valid_o,
	output logic [31:0] resp_frame_o,
	// fuse sense array
	output logic sense_req_o,
	output logic [1:0] sense_ref_o,
	input wire logic sense_ack_i,
	input wire logic [15:0] sense_data_i,
	// default selects and decoded codes
	input wire logic [1:0] buck1_default_peak_select_i,
	input wire logic [1:0] buck1_default_offtime_select_i,
	output logic [5:0] buck1_peak_current_code_o,
	output logic [3:0] buck1_volt_time_product_o,
	// latched trim word
	output logic [23:0] trim_word_o
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic hits_ctm(input logic [31:0] f,
			input logic [1:0] op);
		hits_ctm = (f[otp_trim_pkg::OP_MSB:otp_trim_pkg::OP_LSB] == op) &&
			(f[otp_trim_pkg::ADDR_MSB:otp_trim_pkg::ADDR_LSB] ==
			otp_trim_pkg::CTM_ADDR);
	endfunction

	function automatic logic [5:0] peak_decode(input logic [1:0] sel);
		unique case (sel)
			2'h0: peak_decode = otp_trim_pkg::PEAK_CODE_00;
			2'h1: peak_decode = otp_trim_pkg::PEAK_CODE_01;
			2'h2: peak_decode = otp_trim_pkg::PEAK_CODE_10;
			2'h3: peak_decode = otp_trim_pkg::PEAK_CODE_11;
		endcase
	endfunction

	function automatic logic [3:0] vt_decode(input logic [1:0] sel);
		unique case (sel)
			2'h0: vt_decode = otp_trim_pkg::VT_CODE_00;
			2'h1: vt_decode = otp_trim_pkg::VT_CODE_01;
			2'h2: vt_decode = otp_trim_pkg::VT_CODE_10;
			2'h3: vt_decode = otp_trim_pkg::VT_CODE_11;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	otp_trim_pkg::sense_state_e state_ff, nxt_state;
	logic [1:0] ref_ff, nxt_ref;
	logic [23:0] ctm_ff, nxt_ctm;
	logic [31:0] resp_ff, nxt_resp;
	logic resp_valid_ff, nxt_resp_valid;
	logic [5:0] peak_ff, nxt_peak;
	logic [3:0] vt_ff, nxt_vt;
	logic [31:0] answer;
	logic [2:0] cmd;
	logic wr_hit;
	logic rd_hit;

	assign cmd = frame_i[otp_trim_pkg::CMD_MSB:otp_trim_pkg::CMD_LSB];
	assign wr_hit = frame_valid_i && hits_ctm(frame_i, otp_trim_pkg::OP_WRITE);
	assign rd_hit = frame_valid_i && hits_ctm(frame_i, otp_trim_pkg::OP_READ);

	// answer frame with parity bit
	resp_parity u_parity (
		.status_i(status_i),
		.ctm_i(ctm_ff),
		.frame_o(answer)
	);

	// ---------------------------------------------------------------
	// load, sense and readback
	// ---------------------------------------------------------------
	// loads start a sense cycle; loads arriving during one are dropped
	always_comb begin
		nxt_state = state_ff;
		nxt_ref = ref_ff;
		nxt_ctm = ctm_ff;
		nxt_resp = resp_ff;
		nxt_resp_valid = 1'b0;
		if (rd_hit) begin
			nxt_resp = answer; // see R8
			nxt_resp_valid = 1'b1;
		end
		unique case (state_ff)
			otp_trim_pkg::ST_IDLE: begin
				if (wr_hit && cmd == otp_trim_pkg::CMD_MARGIN) begin
					nxt_ref = otp_trim_pkg::REF_LOW; // see R1
					nxt_state = otp_trim_pkg::ST_SENSE;
				end else if (wr_hit && cmd == otp_trim_pkg::CMD_BLANK) begin
					nxt_ref = otp_trim_pkg::REF_HIGH; // see R5
					nxt_state = otp_trim_pkg::ST_SENSE;
				end
			end
			otp_trim_pkg::ST_SENSE: begin
				if (sense_ack_i) begin
					if (ref_ff == otp_trim_pkg::REF_LOW) begin
						// see R2
						nxt_ctm[otp_trim_pkg::CTM_W-1:otp_trim_pkg::MARGIN_LSB] =
							sense_data_i;
					end else begin
						// see R6
						nxt_ctm[otp_trim_pkg::WORD_MSB:otp_trim_pkg::WORD_LSB] =
							sense_data_i[otp_trim_pkg::WORD_W-1:0];
					end
					nxt_ref = otp_trim_pkg::REF_NORMAL;
					nxt_state = otp_trim_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_state = otp_trim_pkg::ST_IDLE;
				nxt_ref = otp_trim_pkg::REF_NORMAL;
			end
		endcase
	end

	// registers of the sense path; reads never touch ctm (see R12)
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state_ff <= otp_trim_pkg::ST_IDLE;
			ref_ff <= otp_trim_pkg::REF_NORMAL;
			ctm_ff <= otp_trim_pkg::CTM_RESET;
			resp_ff <= otp_trim_pkg::RESP_RESET;
			resp_valid_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			ref_ff <= nxt_ref;
			ctm_ff <= nxt_ctm;
			resp_ff <= nxt_resp;
			resp_valid_ff <= nxt_resp_valid;
		end
	end

	// ---------------------------------------------------------------
	// default codes
	// ---------------------------------------------------------------
	// codes follow the selects while reset is held, then stay put
	always_comb begin
		nxt_peak = peak_ff;
		nxt_vt = vt_ff;
		if (!resetn_i) begin
			nxt_peak = peak_decode(buck1_default_peak_select_i); // see R9
			nxt_vt = vt_decode(buck1_default_offtime_select_i); // see R10
		end
	end

	always_ff @(posedge clk_i) begin
		peak_ff <= nxt_peak;
		vt_ff <= nxt_vt;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign sense_req_o = (state_ff == otp_trim_pkg::ST_SENSE);
	assign sense_ref_o = ref_ff;
	assign resp_valid_o = resp_valid_ff;
	assign resp_frame_o = resp_ff;
	assign trim_word_o = ctm_ff;
	assign buck1_peak_current_code_o = peak_ff;
	assign buck1_volt_time_product_o = vt_ff;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking

	sequence margin_cmd_s;
		wr_hit && cmd == otp_trim_pkg::CMD_MARGIN &&
			state_ff == otp_trim_pkg::ST_IDLE;
	endsequence

	sequence blank_cmd_s;
		wr_hit && cmd == otp_trim_pkg::CMD_BLANK &&
			state_ff == otp_trim_pkg::ST_IDLE;
	endsequence

	sequence sense_done_s;
		sense_req_o && sense_ack_i;
	endsequence

	margin_start_a: assert property (disable iff (!resetn_i) // see R1
		margin_cmd_s |=> sense_req_o && sense_ref_o == otp_trim_pkg::REF_LOW)
		else $error("margin load did not start a low reference sense");

	blank_start_a: assert property (disable iff (!resetn_i) // see R5
		blank_cmd_s |=> sense_req_o && sense_ref_o == otp_trim_pkg::REF_HIGH)
		else $error("blank load did not start a high reference sense");

	margin_store_a: assert property (disable iff (!resetn_i) // see R2
		sense_done_s ##0 (sense_ref_o == otp_trim_pkg::REF_LOW) |=>
		trim_word_o[23:8] == $past(sense_data_i) &&
		trim_word_o[7:0] == $past(trim_word_o[7:0]) && !sense_req_o)
		else $error("margin result not stored in upper sixteen bits");

	blank_store_a: assert property (disable iff (!resetn_i) // see R6
		sense_done_s ##0 (sense_ref_o == otp_trim_pkg::REF_HIGH) |=>
		trim_word_o[20:13] == $past(sense_data_i[7:0]) &&
		trim_word_o[23:21] == $past(trim_word_o[23:21]) &&
		trim_word_o[12:0] == $past(trim_word_o[12:0]))
		else $error("blank result not stored in bits 20 to 13");

	result_hold_a: assert property (disable iff (!resetn_i) // see R12
		!(sense_req_o && sense_ack_i) |=> $stable(trim_word_o))
		else $error("latched trim word changed without a sense");

	read_answer_a: assert property (disable iff (!resetn_i) // see R8
		rd_hit |=> resp_valid_o && resp_frame_o[23:1] == $past(ctm_ff[23:1])
		&& resp_frame_o[31:24] == $past(status_i))
		else $error("read answer does not carry the trim word");

	odd_parity_a: assert property (disable iff (!resetn_i) // see R8
		resp_valid_o |-> ^resp_frame_o == 1'b1)
		else $error("answer frame parity is not odd");

	peak_default_a: assert property ( // see R9
		!resetn_i ##1 resetn_i |-> buck1_peak_current_code_o ==
		(($past(buck1_default_peak_select_i) == 2'h0) ? 6'h20 :
		($past(buck1_default_peak_select_i) == 2'h1) ? 6'h00 :
		($past(buck1_default_peak_select_i) == 2'h2) ? 6'h31 : 6'h3F))
		else $error("peak default code wrong after reset");

	vt_default_a: assert property ( // see R10
		!resetn_i ##1 resetn_i |-> buck1_volt_time_product_o ==
		(($past(buck1_default_offtime_select_i) == 2'h0) ? 4'hF :
		($past(buck1_default_offtime_select_i) == 2'h1) ? 4'hB :
		($past(buck1_default_offtime_select_i) == 2'h2) ? 4'h5 : 4'h0))
		else $error("volt-time default code wrong after reset");

	codes_hold_a: assert property ( // see R9
		resetn_i && $past(resetn_i) |-> $stable(buck1_peak_current_code_o)
		&& $stable(buck1_volt_time_product_o))
		else $error("default codes changed outside reset");
endmodule
`default_nettype wire

// file: verilog/otp_trim_pkg.sv
`default_nettype none
package otp_trim_pkg;
	// ---------------------------------------------------------------
	// frame layout
	// ---------------------------------------------------------------
	localparam int FRAME_W = 32;
	localparam int OP_MSB = 31;
	localparam int OP_LSB = 30;
	localparam int ADDR_MSB = 29;
	localparam int ADDR_LSB = 24;
	localparam int CMD_MSB = 23;
	localparam int CMD_LSB = 21;
	localparam int CTM_W = 24;
	localparam int SENSE_W = 16;
	localparam int WORD_W = 8;
	localparam int WORD_MSB = 20;
	localparam int WORD_LSB = 13;
	localparam int MARGIN_LSB = 8;
	localparam int STAT_W = 8;
	// default select fields inside the programmed word
	localparam int PEAK_SEL_MSB = 19;
	localparam int PEAK_SEL_LSB = 18;
	localparam int OFF_SEL_MSB = 17;
	localparam int OFF_SEL_LSB = 16;

	// ---------------------------------------------------------------
	// operation codes, address and commands
	// ---------------------------------------------------------------
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_READ = 2'h1;
	localparam logic [5:0] CTM_ADDR = 6'h3E;
	localparam logic [2:0] CMD_MARGIN = 3'h2;
	localparam logic [2:0] CMD_BLANK = 3'h3;
	localparam logic [2:0] CMD_BURN = 3'h4;
	localparam logic [2:0] CMD_EOT = 3'h7;

	// ---------------------------------------------------------------
	// sense references and reset values
	// ---------------------------------------------------------------
	localparam logic [1:0] REF_NORMAL = 2'h0;
	localparam logic [1:0] REF_LOW = 2'h1;
	localparam logic [1:0] REF_HIGH = 2'h2;
	localparam logic [23:0] CTM_RESET = 24'h000000;
	localparam logic [31:0] RESP_RESET = 32'h00000001;

	// ---------------------------------------------------------------
	// default decode tables
	// ---------------------------------------------------------------
	localparam logic [5:0] PEAK_CODE_00 = 6'h20;
	localparam logic [5:0] PEAK_CODE_01 = 6'h00;
	localparam logic [5:0] PEAK_CODE_10 = 6'h31;
	localparam logic [5:0] PEAK_CODE_11 = 6'h3F;
	localparam logic [3:0] VT_CODE_00 = 4'hF;
	localparam logic [3:0] VT_CODE_01 = 4'hB;
	localparam logic [3:0] VT_CODE_10 = 4'h5;
	localparam logic [3:0] VT_CODE_11 = 4'h0;

	// ---------------------------------------------------------------
	// states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SENSE = 2'b10
	} sense_state_e;
endpackage
`default_nettype wire

// file: verilog/resp_parity.sv
`timescale 1ns/1ns
`default_nettype none
module resp_parity (
	// frame content
	input wire logic [7:0] status_i,
	input wire logic [23:0] ctm_i,
	// assembled answer
	output logic [31:0] frame_o
);
	// the final bit makes the count of ones odd over the whole frame
	always_comb begin
		frame_o = {status_i, ctm_i[23:1], 1'b0};
		frame_o[0] = ~(^frame_o[31:1]); // see R8
	end
endmodule
`default_nettype wire

// file: sim/fuse_array_model.sv
`timescale 1ns/1ns
`default_nettype none
module fuse_array_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// sense request from the block
	input wire logic sense_req_i,
	input wire logic [1:0] sense_ref_i,
	// fuse contents and answer delay
	input wire logic [15:0] margin_data_i,
	input wire logic [7:0] blank_data_i,
	input wire logic [3:0] delay_i,
	// answer to the block
	output logic sense_ack_o,
	output logic [15:0] sense_data_o
);
	logic [3:0] wait_ff;
	// waits delay_i cycles, then answers once for each request
	always_ff @(posedge clk_i) begin
		sense_ack_o <= 1'b0;
		sense_data_o <= ~sense_data_o; // garbage outside the answer
		if (!resetn_i) begin
			wait_ff <= 4'h0;
			sense_data_o <= 16'h5A5A;
		end else if (!sense_req_i || sense_ack_o) begin
			wait_ff <= 4'h0;
		end else if (wait_ff == delay_i) begin
			sense_ack_o <= 1'b1;
			if (sense_ref_i == otp_trim_pkg::REF_LOW) begin
				sense_data_o <= margin_data_i;
			end else begin
				sense_data_o <= {~blank_data_i, blank_data_i};
			end
		end else begin
			wait_ff <= wait_ff + 4'h1;
		end
	end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	typedef struct {
		logic [1:0] psel; logic [1:0] osel; logic [5:0] peak; logic [3:0] vt;
	} row_s;
	row_s rows [4];
	logic clk_i = 1'b0, resetn_i = 1'b0, frame_valid_i = 1'b0;
	logic [31:0] frame_i = 32'h0, resp_frame_o;
	logic [7:0] status_i = 8'h00, blank_data = 8'h00;
	logic [15:0] margin_data = 16'h0000, sense_data_i;
	logic [3:0] delay = 4'h0, buck1_volt_time_product_o;
	logic [1:0] psel = 2'h0, osel = 2'h0, sense_ref_o;
	logic [5:0] buck1_peak_current_code_o;
	logic [23:0] trim_word_o, exp_trim;
	logic [20:0] body = 21'h0;
	logic resp_valid_o, sense_req_o, sense_ack_i;
	int num_errors = 0, tests_run = 0;
	otp_trim_verify_defaults otp_trim_verify_defaults_i (.clk_i(clk_i),
		.resetn_i(resetn_i), .frame_valid_i(frame_valid_i), .frame_i(frame_i),
		.status_i(status_i), .resp_valid_o(resp_valid_o),
		.resp_frame_o(resp_frame_o), .sense_req_o(sense_req_o),
		.sense_ref_o(sense_ref_o), .sense_ack_i(sense_ack_i),
		.sense_data_i(sense_data_i), .buck1_default_peak_select_i(psel),
		.buck1_default_offtime_select_i(osel),
		.buck1_peak_current_code_o(buck1_peak_current_code_o),
		.buck1_volt_time_product_o(buck1_volt_time_product_o),
		.trim_word_o(trim_word_o));
	fuse_array_model fuse_array_model_i (.clk_i(clk_i), .resetn_i(resetn_i),
		.sense_req_i(sense_req_o), .sense_ref_i(sense_ref_o),
		.margin_data_i(margin_data), .blank_data_i(blank_data),
		.delay_i(delay), .sense_ack_o(sense_ack_i),
		.sense_data_o(sense_data_i));
	// ------------------------------------------------------------
	// clock, watchdog and tasks
	// ------------------------------------------------------------
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#200000;
		num_errors++;
		give_verdict();
	end
	task automatic check(string name, logic [31:0] exp, logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// one frame for one cycle; returns just after the taking edge
	task automatic send(logic [1:0] op, logic [2:0] cmd);
		@(posedge clk_i);
		#1 frame_valid_i = 1'b1;
		frame_i = {op, 6'h3E, cmd, body};
		@(posedge clk_i);
		#1 frame_valid_i = 1'b0;
	endtask
	task automatic do_reset();
		@(posedge clk_i);
		#1 resetn_i = 1'b0;
		repeat (4) @(posedge clk_i);
		#1 resetn_i = 1'b1;
	endtask
	task automatic wait_idle();
		// sample one step after each edge so the registered level has settled
		for (int i = 0; i < 40 && sense_req_o !== 1'b0; i++) begin
			@(posedge clk_i);
			#1;
		end
		check("req", 32'h0, {31'h0, sense_req_o});
	endtask
	// read with odd parity in bit 0 of the expected answer
	task automatic read_chk(logic [7:0] st);
		logic [31:0] f;
		status_i = st;
		f = {st, exp_trim[23:1], 1'b0};
		f[0] = ~^f;
		send(2'h1, 3'h0);
		check("resp_valid", 32'h1, {31'h0, resp_valid_o});
		check("resp", f, resp_frame_o);
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rows[0] = '{2'h0, 2'h3, 6'h20, 4'h0};
		rows[1] = '{2'h1, 2'h2, 6'h00, 4'h5};
		rows[2] = '{2'h2, 2'h1, 6'h31, 4'hB};
		rows[3] = '{2'h3, 2'h0, 6'h3F, 4'hF};
		foreach (rows[i]) begin
			psel = rows[i].psel;
			osel = rows[i].osel;
			do_reset();
			check("peak", rows[i].peak, buck1_peak_current_code_o);
			check("vt", rows[i].vt, buck1_volt_time_product_o);
		end
		psel = 2'h0;
		#20 check("peak hold", 6'h3F, buck1_peak_current_code_o);
		check("rst resp", 32'h1, resp_frame_o);
		check("rst trim", 24'h0, trim_word_o);
		// margin load, slow answer, blank load refused while pending
		margin_data = 16'h14D0;
		delay = 4'h9;
		send(2'h0, 3'h2);
		#10 check("ref", 2'h1, sense_ref_o);
		send(2'h0, 3'h3);
		check("ref", 2'h1, sense_ref_o);
		wait_idle();
		exp_trim = {16'h14D0, 8'h00};
		check("trim", exp_trim, trim_word_o);
		read_chk(8'h81);
		check("margin word", {8'hA6, 11'h400}, resp_frame_o[20:2]);
		read_chk(8'h00);
		// blank load, prompt answer, then three burns that are ignored
		// a word unlike the margin one, so a lost blank store shows up
		blank_data = 8'h3C;
		delay = 4'h0;
		send(2'h0, 3'h3);
		#10 check("ref", 2'h2, sense_ref_o);
		wait_idle();
		exp_trim[20:13] = 8'h3C;
		check("trim", exp_trim, trim_word_o);
		read_chk(8'h7E);
		check("blank word", {8'h3C, 12'h800}, resp_frame_o[20:1]);
		// three burns carrying the chosen word; the block must ignore them
		body = {8'hA6, 13'h0000};
		repeat (3) begin
			send(2'h0, 3'h4);
			check("burn", 32'h0, {31'h0, resp_valid_o | sense_req_o});
		end
		body = 21'h0;
		#20 check("trim", exp_trim, trim_word_o);
		give_verdict();
	end
endmodule
`default_nettype wire
